// File: design/pwr_pkg.sv
// Constants, field layouts and carriers of the PWM count and alias registers.
// Assumes an APB master on pclk and the waveform engine outside this bank.
package pwr_pkg;

	localparam int NUM_CH = 3;

	// ------------------------------------------------------------------
	// Per-channel byte register offsets (channel stride below)
	// ------------------------------------------------------------------
	localparam logic [11:0] OFS_PERIOD_LO = 12'h000;
	localparam logic [11:0] OFS_PERIOD_HI = 12'h004;
	localparam logic [11:0] OFS_DELAY_LO = 12'h008;
	localparam logic [11:0] OFS_DELAY_HI = 12'h00C;
	localparam logic [11:0] OFS_COUNT_LO = 12'h010;
	localparam logic [11:0] OFS_COUNT_HI = 12'h014;
	localparam logic [11:0] OFS_CTRL = 12'h018;
	localparam logic [11:0] OFS_RELOAD_CTRL = 12'h01C;
	localparam logic [11:0] CH_STRIDE = 12'h040;

	// ------------------------------------------------------------------
	// Shared register offsets
	// ------------------------------------------------------------------
	localparam logic [11:0] OFS_RUN_ALIAS = 12'h100;
	localparam logic [11:0] OFS_RELOAD_ALIAS = 12'h104;
	localparam logic [11:0] OFS_DRIVE_ALIAS = 12'h108;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h10C;
	localparam logic [11:0] OFS_IRQ_PEND = 12'h110;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int CTRL_ON_BIT = 7;
	localparam int CTRL_OUT_BIT = 5;
	localparam int LDCON_ARMED_BIT = 7;
	localparam int IRQ_LSB = 4;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [2:0] ALIAS_RST = 3'h0;
	localparam logic [2:0] IRQ_RST = 3'h0;
	localparam logic [15:0] COUNT_POWERUP = 16'h0000;

	typedef struct packed {
		logic [15:0] period_count;
		logic [15:0] start_delay_count;
		logic [15:0] counter_value;
	} pwr_counts_t;

endpackage

// File: design/pwr_regs.sv
// APB register bank for three PWM channels: count bytes and alias bits.
// Assumes an APB master on pclk; the waveform engine drives timer and
// reload/event inputs on the same clock.
`timescale 1ns/1ps
module pwr_regs #(
	parameter int NUM_CH = pwr_pkg::NUM_CH
) (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Power-on / brown-out reset, active low
	input wire logic por_n,
	// Waveform engine
	input wire logic [NUM_CH-1:0] engine_count_inc,
	input wire logic [NUM_CH-1:0] engine_reload_done,
	input wire logic [NUM_CH-1:0] engine_match_evt,
	input wire logic [NUM_CH-1:0] engine_drive_level,
	output pwr_pkg::pwr_counts_t [NUM_CH-1:0] chan_counts,
	output logic [NUM_CH-1:0] module_on,
	output logic [NUM_CH-1:0] reload_armed,
	output logic [NUM_CH-1:0] drive_level,
	// Interrupt
	output logic irq
);

	// Alias registers have room for three channel bits only
	if (NUM_CH != 3) begin : g_bad_num_ch
		$error("pwr_regs: alias registers serve exactly 3 channels");
	end

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	logic acc;
	logic wr;
	logic [7:0] wbyte;
	logic hit;
	pwr_pkg::pwr_counts_t [NUM_CH-1:0] cnt_ff;
	logic [NUM_CH-1:0] on_ff;
	logic [NUM_CH-1:0] armed_ff;
	logic [NUM_CH-1:0] out_ff;
	logic [NUM_CH-1:0] mask_ff;
	logic [NUM_CH-1:0] pend_ff;
	logic [31:0] nxt_rdata;

	assign acc = psel && penable;
	assign wr = acc && pwrite && pstrb[0];
	assign wbyte = pwdata[7:0];
	assign pready = 1'b1;
	assign pslverr = acc && !hit;

	function automatic logic is_ch(input logic [11:0] a,
		input logic [11:0] ofs, input int ch);
		return a == 12'(ofs + 12'(ch) * pwr_pkg::CH_STRIDE);
	endfunction

	// ------------------------------------------------------------------
	// Count bytes
	// ------------------------------------------------------------------
	// Counts reset only with power-on; a plain presetn leaves them alone.
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : gch
			always_ff @(posedge pclk or negedge por_n) begin
				if (!por_n) begin
					cnt_ff[g] <= {3{pwr_pkg::COUNT_POWERUP}};
				end else begin
					if (wr && is_ch(paddr, pwr_pkg::OFS_COUNT_HI, g))
						cnt_ff[g].counter_value[15:8] <= wbyte;
					else if (wr && is_ch(paddr, pwr_pkg::OFS_COUNT_LO, g))
						cnt_ff[g].counter_value[7:0] <= wbyte;
					else if (engine_count_inc[g])
						cnt_ff[g].counter_value <=
							cnt_ff[g].counter_value + 16'h0001;
					if (wr && is_ch(paddr, pwr_pkg::OFS_PERIOD_LO, g))
						cnt_ff[g].period_count[7:0] <= wbyte;
					if (wr && is_ch(paddr, pwr_pkg::OFS_PERIOD_HI, g))
						cnt_ff[g].period_count[15:8] <= wbyte;
					if (wr && is_ch(paddr, pwr_pkg::OFS_DELAY_HI, g))
						cnt_ff[g].start_delay_count[15:8] <= wbyte;
					if (wr && is_ch(paddr, pwr_pkg::OFS_DELAY_LO, g))
						cnt_ff[g].start_delay_count[7:0] <= wbyte;
				end
			end

			// Alias and own control bits share one flop each
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					on_ff[g] <= 1'b0;
					out_ff[g] <= 1'b0;
				end else begin
					if (wr && paddr == pwr_pkg::OFS_RUN_ALIAS)
						on_ff[g] <= wbyte[g];
					else if (wr && is_ch(paddr, pwr_pkg::OFS_CTRL, g))
						on_ff[g] <= wbyte[pwr_pkg::CTRL_ON_BIT];
					if (on_ff[g])
						out_ff[g] <= engine_drive_level[g];
					else if (wr && paddr == pwr_pkg::OFS_DRIVE_ALIAS)
						out_ff[g] <= wbyte[g];
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					armed_ff[g] <= 1'b0;
				end else begin
					if (engine_reload_done[g])
						armed_ff[g] <= 1'b0;
					else if (wr && paddr == pwr_pkg::OFS_RELOAD_ALIAS)
						armed_ff[g] <= wbyte[g];
					else if (wr && is_ch(paddr, pwr_pkg::OFS_RELOAD_CTRL, g))
						armed_ff[g] <= wbyte[pwr_pkg::LDCON_ARMED_BIT];
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// Interrupt
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_ff <= pwr_pkg::IRQ_RST;
		end else if (wr && paddr == pwr_pkg::OFS_IRQ_MASK) begin
			mask_ff <= wbyte[pwr_pkg::IRQ_LSB +: NUM_CH];
		end
	end

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_ff <= pwr_pkg::IRQ_RST;
		end else if (wr && paddr == pwr_pkg::OFS_IRQ_PEND) begin
			pend_ff <= (pend_ff & ~wbyte[pwr_pkg::IRQ_LSB +: NUM_CH]) |
				engine_match_evt;
		end else begin
			pend_ff <= pend_ff | engine_match_evt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(nxt_pend_masked());
	end

	function automatic logic [NUM_CH-1:0] nxt_pend_masked();
		return (pend_ff | engine_match_evt) & mask_ff;
	endfunction

	// ------------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------------
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		hit = 1'b0;
		if (paddr == pwr_pkg::OFS_RUN_ALIAS) begin
			hit = 1'b1;
			nxt_rdata[2:0] = on_ff;
		end else if (paddr == pwr_pkg::OFS_RELOAD_ALIAS) begin
			hit = 1'b1;
			nxt_rdata[2:0] = armed_ff;
		end else if (paddr == pwr_pkg::OFS_DRIVE_ALIAS) begin
			hit = 1'b1;
			nxt_rdata[2:0] = out_ff;
		end else if (paddr == pwr_pkg::OFS_IRQ_MASK) begin
			hit = 1'b1;
			nxt_rdata[pwr_pkg::IRQ_LSB +: NUM_CH] = mask_ff;
		end else if (paddr == pwr_pkg::OFS_IRQ_PEND) begin
			hit = 1'b1;
			nxt_rdata[pwr_pkg::IRQ_LSB +: NUM_CH] = pend_ff;
		end
		for (int c = 0; c < NUM_CH; c++) begin
			if (is_ch(paddr, pwr_pkg::OFS_PERIOD_LO, c)) begin
				hit = 1'b1;
				nxt_rdata[7:0] = cnt_ff[c].period_count[7:0];
			end
			if (is_ch(paddr, pwr_pkg::OFS_PERIOD_HI, c)) begin
				hit = 1'b1;
				nxt_rdata[7:0] = cnt_ff[c].period_count[15:8];
			end
			if (is_ch(paddr, pwr_pkg::OFS_DELAY_LO, c)) begin
				hit = 1'b1;
				nxt_rdata[7:0] = cnt_ff[c].start_delay_count[7:0];
			end
			if (is_ch(paddr, pwr_pkg::OFS_DELAY_HI, c)) begin
				hit = 1'b1;
				nxt_rdata[7:0] = cnt_ff[c].start_delay_count[15:8];
			end
			if (is_ch(paddr, pwr_pkg::OFS_COUNT_LO, c)) begin
				hit = 1'b1;
				nxt_rdata[7:0] = cnt_ff[c].counter_value[7:0];
			end
			if (is_ch(paddr, pwr_pkg::OFS_COUNT_HI, c)) begin
				hit = 1'b1;
				nxt_rdata[7:0] = cnt_ff[c].counter_value[15:8];
			end
			if (is_ch(paddr, pwr_pkg::OFS_CTRL, c)) begin
				hit = 1'b1;
				nxt_rdata[pwr_pkg::CTRL_ON_BIT] = on_ff[c];
				nxt_rdata[pwr_pkg::CTRL_OUT_BIT] = out_ff[c];
			end
			if (is_ch(paddr, pwr_pkg::OFS_RELOAD_CTRL, c)) begin
				hit = 1'b1;
				nxt_rdata[pwr_pkg::LDCON_ARMED_BIT] = armed_ff[c];
			end
		end
	end

	// Data output registered in the setup phase, valid in access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= nxt_rdata;
	end

	assign chan_counts = cnt_ff;
	assign module_on = on_ff;
	assign reload_armed = armed_ff;
	assign drive_level = out_ff;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	sequence s_alias_wr(logic [11:0] a);
		psel && penable && pwrite && pstrb[0] && paddr == a;
	endsequence

	// Read data is captured in the setup cycle
	sequence s_rd_setup(logic [11:0] a);
		psel && !penable && !pwrite && paddr == a;
	endsequence

	a_run_alias_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_alias_wr(pwr_pkg::OFS_RUN_ALIAS) |=> on_ff == $past(pwdata[2:0]))
		else $error("run alias write not stored");

	a_run_ctrl_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_alias_wr(pwr_pkg::OFS_CTRL + pwr_pkg::CH_STRIDE)
		|=> on_ff[1] == $past(pwdata[pwr_pkg::CTRL_ON_BIT]))
		else $error("control write not seen by run alias");

	a_run_alias_read: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_rd_setup(pwr_pkg::OFS_RUN_ALIAS) |=> prdata[2:0] == $past(on_ff))
		else $error("run alias read wrong");

	a_reload_done_clr: assert property (
		@(posedge pclk) disable iff (!presetn)
		|engine_reload_done
		|=> (armed_ff & $past(engine_reload_done)) == 3'h0)
		else $error("armed bit not cleared by reload");

	a_arm_alias_wr: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_alias_wr(pwr_pkg::OFS_RELOAD_ALIAS) ##0 !(|engine_reload_done)
		|=> armed_ff == $past(pwdata[2:0]))
		else $error("reload alias write not stored");

	a_arm_ctrl_wr: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_alias_wr(pwr_pkg::OFS_RELOAD_CTRL + pwr_pkg::CH_STRIDE)
		##0 !engine_reload_done[1]
		|=> armed_ff[1] == $past(pwdata[pwr_pkg::LDCON_ARMED_BIT]))
		else $error("reload control write not seen by alias");

	a_arm_alias_read: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_rd_setup(pwr_pkg::OFS_RELOAD_ALIAS)
		|=> prdata[2:0] == $past(armed_ff))
		else $error("reload alias read wrong");

	a_drive_follow: assert property (
		@(posedge pclk) disable iff (!presetn)
		on_ff[0] |=> out_ff[0] == $past(engine_drive_level[0]))
		else $error("drive bit not tracking engine");

	a_drive_alias_read: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_rd_setup(pwr_pkg::OFS_DRIVE_ALIAS)
		|=> prdata[2:0] == $past(out_ff))
		else $error("drive alias read wrong");

	a_ctrl_read: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_rd_setup(pwr_pkg::OFS_CTRL + pwr_pkg::CH_STRIDE)
		|=> prdata[pwr_pkg::CTRL_ON_BIT] == $past(on_ff[1]) &&
		prdata[pwr_pkg::CTRL_OUT_BIT] == $past(out_ff[1]))
		else $error("control read disagrees with alias bits");

	a_alias_upper_zero: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_rd_setup(pwr_pkg::OFS_RUN_ALIAS) |=> prdata[31:3] == 29'h0)
		else $error("alias upper bits not zero");

	a_reload_upper_zero: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_rd_setup(pwr_pkg::OFS_RELOAD_ALIAS) |=> prdata[31:3] == 29'h0)
		else $error("reload alias upper bits not zero");

	a_drive_upper_zero: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_rd_setup(pwr_pkg::OFS_DRIVE_ALIAS) |=> prdata[31:3] == 29'h0)
		else $error("drive alias upper bits not zero");

	a_alias_clr_rst: assert property (
		@(posedge pclk)
		!presetn |-> on_ff == 3'h0 && armed_ff == 3'h0 && out_ff == 3'h0)
		else $error("alias bits not cleared by reset");

	a_period_lo_wr: assert property (
		@(posedge pclk) disable iff (!por_n)
		s_alias_wr(pwr_pkg::OFS_PERIOD_LO)
		|=> cnt_ff[0].period_count[7:0] == $past(pwdata[7:0]))
		else $error("period low write lost");

	a_period_hi_wr: assert property (
		@(posedge pclk) disable iff (!por_n)
		s_alias_wr(pwr_pkg::OFS_PERIOD_HI)
		|=> cnt_ff[0].period_count[15:8] == $past(pwdata[7:0]))
		else $error("period high write lost");

	a_delay_hi_wr: assert property (
		@(posedge pclk) disable iff (!por_n)
		s_alias_wr(pwr_pkg::OFS_DELAY_HI)
		|=> cnt_ff[0].start_delay_count[15:8] == $past(pwdata[7:0]))
		else $error("delay high write lost");

	a_delay_lo_wr: assert property (
		@(posedge pclk) disable iff (!por_n)
		s_alias_wr(pwr_pkg::OFS_DELAY_LO)
		|=> cnt_ff[0].start_delay_count[7:0] == $past(pwdata[7:0]))
		else $error("delay low write lost");

	a_count_hi_wr: assert property (
		@(posedge pclk) disable iff (!por_n)
		s_alias_wr(pwr_pkg::OFS_COUNT_HI)
		|=> cnt_ff[0].counter_value[15:8] == $past(pwdata[7:0]))
		else $error("counter high write lost");

	a_count_lo_wr: assert property (
		@(posedge pclk) disable iff (!por_n)
		s_alias_wr(pwr_pkg::OFS_COUNT_LO)
		|=> cnt_ff[0].counter_value[7:0] == $past(pwdata[7:0]))
		else $error("counter low write lost");

	a_count_step: assert property (
		@(posedge pclk) disable iff (!por_n)
		engine_count_inc[0] && !psel
		|=> cnt_ff[0].counter_value ==
		$past(cnt_ff[0].counter_value) + 16'h0001)
		else $error("counter did not step");

	a_counts_hold_rst: assert property (
		@(posedge pclk) disable iff (!por_n)
		!presetn && !(|engine_count_inc) && !psel
		|=> cnt_ff == $past(cnt_ff))
		else $error("counts changed under plain reset");

endmodule

// File: verif/pwr_regs_tb.sv
// Self-checking bench for the PWM count and alias register bank.
// Assumes pwr_pkg is compiled first; the bench plays APB master and engine.
`timescale 1ns/1ps
module pwr_regs_tb;
	logic pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic [3:0] pstrb;
	logic [2:0] e_inc, e_rld, e_evt, e_lvl, mod_on, armed, drv;
	pwr_pkg::pwr_counts_t [2:0] counts;
	logic [33:0] expq[$];
	logic [33:0] note;
	logic [7:0] b [3][6];
	logic [11:0] ofs_tab [8];
	int miscompares, num_checks;

	pwr_regs #(.NUM_CH(3)) pwr_regs_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .por_n(por_n), .engine_count_inc(e_inc),
		.engine_reload_done(e_rld), .engine_match_evt(e_evt),
		.engine_drive_level(e_lvl), .chan_counts(counts),
		.module_on(mod_on), .reload_armed(armed), .drive_level(drv),
		.irq(irq));

	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	// --------------------------------------------------------------
	// Bus tasks
	// --------------------------------------------------------------
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] wd, input logic [3:0] s, input logic e,
		input logic [31:0] x);
		expq.push_back({w, e, x});
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] wd);
		apb(1'b1, a, wd, 4'hF, 1'b0, 32'h0);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0, 4'hF, 1'b0, x);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] x);
		#1;
		num_checks++;
		if (got !== x) begin
			miscompares++;
			$display("[ERR] %0t output %h expected %h", $time, got, x);
		end
		@(posedge pclk);
	endtask

	task automatic pulse(input int which, input logic [2:0] v);
		case (which)
			0: e_inc <= v;
			1: e_rld <= v;
			default: e_evt <= v;
		endcase
		@(posedge pclk);
		e_inc <= 3'h0;
		e_rld <= 3'h0;
		e_evt <= 3'h0;
		repeat (2) @(posedge pclk);
	endtask

	function automatic logic [11:0] ca(input int c, input int k);
		return ofs_tab[k] + 12'(c) * pwr_pkg::CH_STRIDE;
	endfunction

	task automatic rd_counts;
		for (int c = 0; c < 3; c++) begin
			for (int k = 0; k < 6; k++) begin
				rd(ca(c, k), {24'h0, b[c][k]});
			end
		end
	endtask

	task automatic rd_alias_zero;
		rd(pwr_pkg::OFS_RUN_ALIAS, 32'h0);
		rd(pwr_pkg::OFS_RELOAD_ALIAS, 32'h0);
		rd(pwr_pkg::OFS_DRIVE_ALIAS, 32'h0);
		rd(pwr_pkg::OFS_IRQ_MASK, 32'h0);
		rd(pwr_pkg::OFS_IRQ_PEND, 32'h0);
		chk({31'h0, irq}, 32'h0);
	endtask

	task automatic print_verdict;
		$display("Checks %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Oldest note against each completed transfer
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			note = expq.pop_front();
			num_checks++;
			if (pslverr !== note[32] || (!note[33] && prdata !== note[31:0]))
			begin
				miscompares++;
				$display("[ERR] %0t addr %h read %h", $time, paddr, prdata);
			end
		end
	end

	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		print_verdict();
	end

	initial begin
		ofs_tab = '{pwr_pkg::OFS_PERIOD_LO, pwr_pkg::OFS_PERIOD_HI,
			pwr_pkg::OFS_DELAY_LO, pwr_pkg::OFS_DELAY_HI,
			pwr_pkg::OFS_COUNT_LO, pwr_pkg::OFS_COUNT_HI,
			pwr_pkg::OFS_CTRL, pwr_pkg::OFS_RELOAD_CTRL};
		{presetn, por_n, psel, penable, pwrite} = 5'h00;
		{paddr, pwdata, pstrb} = 48'h0;
		{e_inc, e_rld, e_evt, e_lvl} = 12'h000;
		void'($urandom(93));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		por_n <= 1'b1;
		@(posedge pclk);
		rd_alias_zero();
		// Count bytes written with noisy upper data, then all read back
		for (int c = 0; c < 3; c++) begin
			for (int k = 0; k < 6; k++) begin
				d = $urandom;
				b[c][k] = d[7:0];
				wr(ca(c, k), d);
			end
		end
		rd_counts();
		for (int c = 0; c < 3; c++) begin
			chk(counts[c].period_count, {b[c][1], b[c][0]});
			chk(counts[c].start_delay_count, {b[c][3], b[c][2]});
			chk(counts[c].counter_value, {b[c][5], b[c][4]});
		end
		// Drive alias set while stopped, then engine level while on
		wr(pwr_pkg::OFS_DRIVE_ALIAS, 32'hFFFFFFFA);
		rd(pwr_pkg::OFS_DRIVE_ALIAS, 32'h2);
		chk(drv, 32'h2);
		e_lvl <= 3'b100;
		wr(pwr_pkg::OFS_RUN_ALIAS, 32'hFFFFFFFD);
		rd(pwr_pkg::OFS_RUN_ALIAS, 32'h5);
		wr(ca(1, 6), 32'h80);
		wr(ca(0, 6), 32'h00);
		rd(pwr_pkg::OFS_RUN_ALIAS, 32'h6);
		chk(mod_on, 32'h6);
		rd(pwr_pkg::OFS_DRIVE_ALIAS, 32'h4);
		rd(ca(1, 6), 32'h80);
		rd(ca(2, 6), 32'hA0);
		// Reload arming, hardware clear and software cancel
		wr(pwr_pkg::OFS_RELOAD_ALIAS, 32'hFFFFFFFF);
		rd(pwr_pkg::OFS_RELOAD_ALIAS, 32'h7);
		pulse(1, 3'b010);
		rd(pwr_pkg::OFS_RELOAD_ALIAS, 32'h5);
		wr(ca(2, 7), 32'h00);
		wr(ca(1, 7), 32'h80);
		rd(pwr_pkg::OFS_RELOAD_ALIAS, 32'h3);
		chk(armed, 32'h3);
		rd(ca(0, 7), 32'h80);
		// Counter carry on a stopped channel, both halves written
		wr(ca(0, 4), 32'hFF);
		wr(ca(0, 5), 32'h12);
		pulse(0, 3'b001);
		b[0][4] = 8'h00;
		b[0][5] = 8'h13;
		rd(ca(0, 4), 32'h0);
		rd(ca(0, 5), 32'h13);
		// Masked events, unmask, then clear channel 0 alone and channels 1 and 2 together
		wr(pwr_pkg::OFS_IRQ_MASK, 32'h0);
		pulse(2, 3'b111);
		chk({31'h0, irq}, 32'h0);
		rd(pwr_pkg::OFS_IRQ_PEND, 32'h70);
		wr(pwr_pkg::OFS_IRQ_MASK, 32'hFFFFFFFF);
		rd(pwr_pkg::OFS_IRQ_MASK, 32'h70);
		chk({31'h0, irq}, 32'h1);
		wr(pwr_pkg::OFS_IRQ_PEND, 32'h10);
		rd(pwr_pkg::OFS_IRQ_PEND, 32'h60);
		wr(pwr_pkg::OFS_IRQ_PEND, 32'h60);
		rd(pwr_pkg::OFS_IRQ_PEND, 32'h0);
		chk({31'h0, irq}, 32'h0);
		// Unmapped place and a write without the low strobe
		apb(1'b1, 12'h200, 32'hFF, 4'hF, 1'b1, 32'h0);
		apb(1'b0, 12'h200, 32'h0, 4'hF, 1'b1, 32'h0);
		apb(1'b1, ca(0, 0), ~{24'h0, b[0][0]}, 4'hE, 1'b0, 32'h0);
		rd(ca(0, 0), {24'h0, b[0][0]});
		// Plain reset keeps counts and clears alias bits
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd_alias_zero();
		rd_counts();
		// Power-on reset takes the counts to zero as well
		por_n <= 1'b0;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		por_n <= 1'b1;
		presetn <= 1'b1;
		@(posedge pclk);
		b = '{default: 8'h00};
		rd_counts();
		print_verdict();
	end
endmodule
